// [common/pbp_if.sv]
// Link between the phase-step controller and the PLL reconfiguration end.
// Assumes both ends run on the same system clock; the scan clock is a level.
`timescale 1ns/10ps
interface pbp_if;
  logic       scan_clk;
  logic       shift_request;
  logic       shift_direction;
  logic [3:0] shift_target_sel;
  logic       shift_complete;

  modport dev (input scan_clk, input shift_request, input shift_direction,
               input shift_target_sel, output shift_complete);
  modport ctl (output scan_clk, output shift_request, output shift_direction,
               output shift_target_sel, input shift_complete);
endinterface

// [common/pbp_pkg.sv]
// Shared constants for the PLL bypass and phase-step control pair.
// Assumes one 50 MHz system clock shared by both ends.
package pbp_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ          = 50;
  localparam int          SCAN_HALF_CYC    = 4;    // Scan clock half period in CLK cycles.
  localparam int          SHIFT_TIME_NS    = 100;  // Internal shift time of the phase tap.
  localparam int          SHIFT_CYC        = (SHIFT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0]  SHIFT_CNT_LOAD   = 4'(SHIFT_CYC - 1);
  // ----------------------------------------------------------------
  // Counter setting layout: {odd_fix, low[7:0], bypass, high[7:0]}
  // ----------------------------------------------------------------
  localparam int          CNT_W            = 18;
  localparam int          CNT_BYP_BIT      = 8;
  localparam int          CNT_ODD_BIT      = 17;
  localparam int          NUM_CNT          = 12;   // 0 = input div, 1 = feedback, 2.. outputs.
  localparam logic [3:0]  SEL_ALL_OUT      = 4'h0;
  localparam logic [3:0]  SEL_FB           = 4'h1;
  localparam logic [3:0]  SEL_LAST_SMALL   = 4'h8; // Output counter 6.
  localparam logic [3:0]  SEL_LAST_LARGE   = 4'hb; // Output counter 9.
  localparam logic [17:0] CNT_RESET        = 18'h00100; // Bypassed after reset.
  localparam logic [1:0]  POST_DIV_FACTOR  = 2'h2;
  localparam logic [2:0]  TAP_RESET        = 3'h0;
  // ----------------------------------------------------------------
  // Controller register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL        = 8'h00;
  localparam logic [7:0]  ADDR_STATUS      = 8'h04;
  localparam int          CTRL_DIR_BIT     = 4;
  localparam int          CTRL_GO_BIT      = 8;
  localparam int          STAT_BUSY_BIT    = 0;
  localparam int          STAT_DONE_BIT    = 1;

  typedef enum logic [1:0] {HTRANS_IDLE = 2'h0, HTRANS_NONSEQ = 2'h2} pbp_htrans_t;
endpackage

// [rtl/pbp_pll_dev.sv]
// PLL reconfiguration end: counter bypass decode and dynamic phase stepping.
// Assumes the scan clock level arrives synchronous to CLK and toggles freely.
`timescale 1ns/10ps
module pbp_pll_dev #(
  parameter bit LARGE = 1'b1
) (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  pbp_if.dev               LINK,
  input  wire logic [3:0]  CNT_SEL,
  input  wire logic        CNT_WR,
  input  wire logic [17:0] CNT_DATA,
  input  wire logic        POST_WR,
  input  wire logic        POST_DATA,
  output logic      [8:0]  DIV_FACTOR,
  output logic      [1:0]  POST_FACTOR,
  output logic      [17:0] CNT_SETTING,
  output logic      [35:0] PHASE_TAPS,
  output logic             SHIFTING
);
  typedef enum logic [1:0] {ST_IDLE, ST_LATCHED, ST_SHIFT} pbp_dev_st_t;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // factor of one when bypassed, else high plus low
  function automatic logic [8:0] cnt_factor(input logic [17:0] s);
    if (s[pbp_pkg::CNT_BYP_BIT]) begin
      cnt_factor = 9'h001;
    end else begin
      cnt_factor = {1'b0, s[7:0]} + {1'b0, s[16:9]};
    end
  endfunction

  function automatic logic sel_hits(input logic [3:0] sel, input int idx);
    logic [3:0] last;
    last     = LARGE ? pbp_pkg::SEL_LAST_LARGE : pbp_pkg::SEL_LAST_SMALL;
    sel_hits = 1'b0;
    if (idx >= 1 && idx <= int'(last)) begin
      if (sel == pbp_pkg::SEL_ALL_OUT) begin
        sel_hits = (idx >= 2);
      end else begin
        sel_hits = (int'(sel) == idx);
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [17:0]  cnt_set [pbp_pkg::NUM_CNT];
  logic [2:0]   tap_reg [pbp_pkg::NUM_CNT];
  logic         post_reg;
  pbp_dev_st_t  st_reg;
  logic         rise_seen_reg;
  logic         armed_reg;
  logic         dir_reg;
  logic [3:0]   sel_reg;
  logic [3:0]   timer_reg;
  logic         scan_prev_reg;
  logic         done_reg;
  logic         scan_rise;
  logic         scan_fall;

  // Edge enables of the scan clock; the link is synchronous to CLK so no synchroniser.
  assign scan_rise = LINK.scan_clk & ~scan_prev_reg;
  assign scan_fall = ~LINK.scan_clk & scan_prev_reg;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      scan_prev_reg <= 1'b0;
    end else begin
      scan_prev_reg <= LINK.scan_clk;
    end
  end

  // Counter settings; each carries count, bypass and odd-duty bits.
  // setting layout
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < pbp_pkg::NUM_CNT; i++) begin
        cnt_set[i] <= pbp_pkg::CNT_RESET;
      end
      post_reg <= 1'b0;
    end else begin
      if (CNT_WR && int'(CNT_SEL) < pbp_pkg::NUM_CNT) begin
        cnt_set[CNT_SEL] <= CNT_DATA;
      end
      if (POST_WR) begin
        post_reg <= POST_DATA;
      end
    end
  end

  // Read-back of the selected counter's effective factor and raw setting.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      DIV_FACTOR  <= 9'h001;
      CNT_SETTING <= 18'h00000;
      POST_FACTOR <= 2'h1;
    end else begin
      if (int'(CNT_SEL) < pbp_pkg::NUM_CNT) begin
        DIV_FACTOR  <= cnt_factor(cnt_set[CNT_SEL]);
        CNT_SETTING <= cnt_set[CNT_SEL];
      end else begin
        DIV_FACTOR  <= 9'h001;
        CNT_SETTING <= 18'h00000;
      end
      POST_FACTOR <= post_reg ? pbp_pkg::POST_DIV_FACTOR : 2'h1;
    end
  end

  // Step sequencer: latch on a fall, act on the second rise, finish on its own timer.
  // The timer runs on CLK, not the scan clock, so done may rise mid scan cycle.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_reg        <= ST_IDLE;
      rise_seen_reg <= 1'b0;
      armed_reg     <= 1'b1;
      dir_reg       <= 1'b0;
      sel_reg       <= 4'h0;
      timer_reg     <= 4'h0;
      done_reg      <= 1'b1;
    end else begin
      if (scan_fall && !LINK.shift_request) begin
        armed_reg <= 1'b1;
      end
      unique case (st_reg)
        ST_IDLE: begin
          if (scan_fall && LINK.shift_request && armed_reg) begin
            st_reg        <= ST_LATCHED;
            rise_seen_reg <= 1'b0;
            armed_reg     <= 1'b0;
          end
        end
        ST_LATCHED: begin
          if (scan_rise) begin
            rise_seen_reg <= 1'b1;
            if (rise_seen_reg) begin
              sel_reg   <= LINK.shift_target_sel;
              dir_reg   <= LINK.shift_direction;
              done_reg  <= 1'b0;
              timer_reg <= pbp_pkg::SHIFT_CNT_LOAD;
              st_reg    <= ST_SHIFT;
            end
          end
        end
        ST_SHIFT: begin
          if (timer_reg == 4'h0) begin
            done_reg <= 1'b1;
            st_reg   <= ST_IDLE;
          end else begin
            timer_reg <= timer_reg - 4'h1;
          end
        end
        default: begin
          st_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Tap update at the end of a shift; taps wrap so steps never run out.
  // no scan load
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < pbp_pkg::NUM_CNT; i++) begin
        tap_reg[i] <= pbp_pkg::TAP_RESET;
      end
    end else if (st_reg == ST_SHIFT && timer_reg == 4'h0) begin
      for (int i = 0; i < pbp_pkg::NUM_CNT; i++) begin
        if (sel_hits(sel_reg, i)) begin
          tap_reg[i] <= dir_reg ? tap_reg[i] + 3'h1 : tap_reg[i] - 3'h1;
        end
      end
    end
  end

  // Outputs, all taken from flip-flops.
  always_comb begin
    for (int i = 0; i < pbp_pkg::NUM_CNT; i++) begin
      PHASE_TAPS[3*i +: 3] = tap_reg[i];
    end
  end

  assign SHIFTING            = ~done_reg;
  assign LINK.shift_complete = done_reg;
endmodule

// [rtl/pbp_scan_div.sv]
// Scan clock divider: a level plus one-cycle rise and fall enables.
// Assumes a single system clock; the level is only ever sampled, never used as a clock.
`timescale 1ns/10ps
module pbp_scan_div (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      scan_clk_reg,
  output logic      rise,
  output logic      fall
);
  logic [3:0] cnt_reg;

  // Free-running divider; the scan clock never stops so the far end can count edges.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg      <= 4'h0;
      scan_clk_reg <= 1'b0;
      rise         <= 1'b0;
      fall         <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (cnt_reg == 4'(pbp_pkg::SCAN_HALF_CYC - 1)) begin
        cnt_reg      <= 4'h0;
        scan_clk_reg <= ~scan_clk_reg;
        rise         <= ~scan_clk_reg;
        fall         <= scan_clk_reg;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule

// [rtl/pbp_step_ctl.sv]
// Phase-step controller: AHB-Lite registers and the step request handshake.
// Assumes a single AHB-Lite master and the PLL end on the other side of pbp_if.
`timescale 1ns/10ps
module pbp_step_ctl (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic      [31:0] HRDATA,
  pbp_if.ctl               LINK
);
  typedef enum logic [2:0] {C_IDLE, C_SETUP, C_HOLD, C_WAIT_HIGH, C_GAP} pbp_ctl_st_t;

  logic        scan_clk;
  logic        scan_rise;
  logic        scan_fall;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [3:0]  sel_cfg_reg;
  logic        dir_cfg_reg;
  logic        go_reg;
  logic        go_set;
  logic        done_meta_reg;
  logic        done_sync_reg;
  logic        seen_low_reg;
  logic        hold_two_reg;
  logic [15:0] step_cnt_reg;
  logic        req_reg;
  logic        dir_reg;
  logic [3:0]  sel_reg;
  pbp_ctl_st_t st_reg;

  pbp_scan_div u_div (
    .clk          (CLK),
    .rst_n        (RESETN),
    .scan_clk_reg (scan_clk),
    .rise         (scan_rise),
    .fall         (scan_fall)
  );

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Zero wait states; read data is formed in the address phase so it leaves a flop.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      HRDATA      <= 32'h00000000;
    end else if (HREADY) begin
      wr_pend_reg <= HSEL && HTRANS[1] && HWRITE;
      wr_addr_reg <= HADDR[7:0];
      HRDATA      <= 32'h00000000;
      if (HSEL && HTRANS[1] && !HWRITE) begin
        if (HADDR[7:0] == pbp_pkg::ADDR_CTRL) begin
          HRDATA <= {27'h0000000, dir_cfg_reg, sel_cfg_reg};
        end else if (HADDR[7:0] == pbp_pkg::ADDR_STATUS) begin
          HRDATA <= {step_cnt_reg, 14'h0000, done_sync_reg, (go_reg || st_reg != C_IDLE)};
        end
      end
    end
  end

  assign go_set = wr_pend_reg && (wr_addr_reg == pbp_pkg::ADDR_CTRL) &&
                  HWDATA[pbp_pkg::CTRL_GO_BIT];

  // Control register; go is held pending until the sequencer takes it.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sel_cfg_reg <= 4'h0;
      dir_cfg_reg <= 1'b0;
      go_reg      <= 1'b0;
    end else begin
      if (wr_pend_reg && wr_addr_reg == pbp_pkg::ADDR_CTRL) begin
        sel_cfg_reg <= HWDATA[3:0];
        dir_cfg_reg <= HWDATA[pbp_pkg::CTRL_DIR_BIT];
      end
      // Set wins over the take so a go written in that cycle is not lost.
      if (go_set) begin
        go_reg <= 1'b1;
      end else if (st_reg == C_IDLE && scan_rise) begin
        go_reg <= 1'b0;
      end
    end
  end

  // Done can rise on the far end's own timing, so it is resynchronised.
  // done synchroniser
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      done_meta_reg <= 1'b1;
      done_sync_reg <= 1'b1;
    end else begin
      done_meta_reg <= LINK.shift_complete;
      done_sync_reg <= done_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Step handshake, all changes on scan clock rising edges except the seen_low_reg set
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_reg       <= C_IDLE;
      req_reg      <= 1'b0;
      dir_reg      <= 1'b0;
      sel_reg      <= 4'h0;
      seen_low_reg <= 1'b0;
      hold_two_reg <= 1'b0;
      step_cnt_reg <= 16'h0000;
    end else begin
      // A low done pulse can be shorter than a scan cycle, so remember it.
      if (st_reg == C_HOLD && !done_sync_reg) begin
        seen_low_reg <= 1'b1;
      end
      unique case (st_reg)
        C_IDLE: begin
          if (go_reg && scan_rise) begin
            sel_reg <= sel_cfg_reg;
            dir_reg <= dir_cfg_reg;
            st_reg  <= C_SETUP;
          end
        end
        C_SETUP: begin
          if (scan_rise) begin
            req_reg      <= 1'b1;
            seen_low_reg <= 1'b0;
            hold_two_reg <= 1'b0;
            st_reg       <= C_HOLD;
          end
        end
        C_HOLD: begin
          if (scan_rise) begin
            hold_two_reg <= 1'b1;
            if (hold_two_reg && (seen_low_reg || !done_sync_reg)) begin
              req_reg <= 1'b0;
              st_reg  <= C_WAIT_HIGH;
            end
          end
        end
        C_WAIT_HIGH: begin
          if (scan_rise && done_sync_reg) begin
            step_cnt_reg <= step_cnt_reg + 16'h0001;
            st_reg       <= C_GAP;
          end
        end
        C_GAP: begin
          if (scan_rise) begin
            st_reg <= C_IDLE;
          end
        end
        default: begin
          st_reg <= C_IDLE;
        end
      endcase
    end
  end

  // Outputs from flip-flops except HRESP, which is tied low; the response is always OKAY.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      HREADYOUT <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
    end
  end

  assign HRESP                 = 1'b0;
  assign LINK.scan_clk         = scan_clk;
  assign LINK.shift_request    = req_reg;
  assign LINK.shift_direction  = dir_reg;
  assign LINK.shift_target_sel = sel_reg;
endmodule

// [verification/pbp_link_properties.sv]
// Concurrent checks on the link between the step controller and the PLL end.
// Assumes every link signal is a level synchronous to CLK.
`timescale 1ns/10ps
module pbp_link_properties (
  input  wire logic       CLK,
  input  wire logic       RESETN,
  input  wire logic       scan_clk,
  input  wire logic       shift_request,
  input  wire logic       shift_direction,
  input  wire logic [3:0] shift_target_sel,
  input  wire logic       shift_complete
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic [5:0] hold_cnt;
  logic       seen_low;
  logic       done_q;
  logic [1:0] falls;

  // Request length; it saturates so a stuck request never wraps below the minimum.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) hold_cnt <= 6'h00;
    else if (!shift_request) hold_cnt <= 6'h00;
    else if (hold_cnt != 6'h3f) hold_cnt <= hold_cnt + 6'h01;
  end

  // Remembers that the done flag went low during the present request.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) seen_low <= 1'b0;
    else seen_low <= shift_request && (seen_low || !shift_complete);
  end

  // Counts done falls within one request, to catch a double shift.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      done_q <= 1'b1;
      falls  <= 2'h0;
    end else begin
      done_q <= shift_complete;
      if (!shift_request) falls <= 2'h0;
      else if (done_q && !shift_complete && falls != 2'h3) falls <= falls + 2'h1;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_scan_free_run: assert property (
    $rose(scan_clk) |-> scan_clk[*4] ##1 !scan_clk[*4] ##1 scan_clk)
    else $error("scan clock period wrong");
  chk_done_low_time: assert property (
    $fell(shift_complete) |-> !shift_complete[*5] ##1 shift_complete)
    else $error("done low time wrong");
  chk_done_on_rise: assert property (
    $fell(shift_complete) |-> $past(scan_clk) && !$past(scan_clk, 2))
    else $error("done fell off a scan rise");
  chk_done_needs_req: assert property (
    $fell(shift_complete) |-> shift_request)
    else $error("done fell without request");
  chk_one_per_pulse: assert property (falls <= 2'h1)
    else $error("two shifts in one request");
  chk_req_min_hold: assert property (
    $fell(shift_request) |-> hold_cnt >= 6'd16)
    else $error("request held too briefly");
  chk_release_after_low: assert property (
    $fell(shift_request) |-> seen_low)
    else $error("request released before done low");
  chk_req_gap: assert property (
    $fell(shift_request) |-> !shift_request[*8])
    else $error("request pulses too close");
  chk_start_when_done: assert property (
    $rose(shift_request) |-> shift_complete && $past(shift_complete))
    else $error("request raised while busy");
  chk_setup_stable: assert property (
    shift_request |-> $stable(shift_target_sel) && $stable(shift_direction))
    else $error("select moved during request");

  cov_step: cover property ($fell(shift_complete));
  cov_release: cover property ($fell(shift_request));
  cov_down: cover property ($rose(shift_request) && !shift_direction);
endmodule

// [verification/pll_bypass_and_phase_step_control_tb.sv]
// Testbench joining the step controller and the PLL end through pbp_if.
// Assumes one 50 MHz clock and the register map of pbp_pkg.
`timescale 1ns/10ps
module pll_bypass_and_phase_step_control_tb;
  logic        clk;
  logic        resetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [3:0]  cnt_sel;
  logic        cnt_wr;
  logic [17:0] cnt_data;
  logic        post_wr;
  logic        post_data;
  logic [8:0]  div_factor;
  logic [1:0]  post_factor;
  logic [17:0] cnt_setting;
  logic [35:0] phase_taps;
  logic        shifting;
  logic [31:0] rd;
  logic [2:0]  exp_tap [12];
  logic [15:0] steps;
  int          miscompares;
  int          comparisons;

  pbp_if pbp_if_i ();
  pbp_pll_dev #(.LARGE(1'b1)) pbp_pll_dev_i (.CLK(clk), .RESETN(resetn), .LINK(pbp_if_i),
    .CNT_SEL(cnt_sel), .CNT_WR(cnt_wr), .CNT_DATA(cnt_data), .POST_WR(post_wr),
    .POST_DATA(post_data), .DIV_FACTOR(div_factor), .POST_FACTOR(post_factor),
    .CNT_SETTING(cnt_setting), .PHASE_TAPS(phase_taps), .SHIFTING(shifting));
  pbp_step_ctl pbp_step_ctl_i (.CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .LINK(pbp_if_i));
  pbp_link_properties pbp_link_properties_i (.CLK(clk), .RESETN(resetn),
    .scan_clk(pbp_if_i.scan_clk), .shift_request(pbp_if_i.shift_request),
    .shift_direction(pbp_if_i.shift_direction), .shift_target_sel(pbp_if_i.shift_target_sel),
    .shift_complete(pbp_if_i.shift_complete));

  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [35:0] got, input logic [35:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // A wait that runs out counts as a mismatch and ends the run.
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 100) begin
        miscompares++;
        $display("FAIL %0t wait limit reached", $time);
        summarize();
      end
      @(posedge clk);
    end
  endtask

  // One single word transfer; entered right after a rising edge.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= pbp_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= pbp_pkg::HTRANS_IDLE;
    hwdata <= wd;
    wait_ready();
    q = hrdata;
  endtask

  // Counter and post-scale writes leave two edges for the registered outputs.
  task automatic cnt_write(input logic [3:0] s, input logic [17:0] d);
    cnt_sel  <= s;
    cnt_wr   <= 1'b1;
    cnt_data <= d;
    @(posedge clk);
    cnt_wr   <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic post_write(input logic b);
    post_wr   <= 1'b1;
    post_data <= b;
    @(posedge clk);
    post_wr   <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  function automatic logic [35:0] packed_taps();
    logic [35:0] t;
    for (int i = 0; i < 12; i++) t[3*i +: 3] = exp_tap[i];
    return t;
  endfunction

  // Starts a step, polls status until idle, then compares taps and count.
  task automatic step(input logic [3:0] sel, input logic dir);
    logic [31:0] q;
    int          n;
    logic        seen;
    ahb(1'b1, pbp_pkg::ADDR_CTRL, {23'h000000, 1'b1, 3'h0, dir, sel}, q);
    q = 32'h00000001;
    n = 0;
    seen = 1'b0;
    // The SHIFTING output stands for five cycles, so sampling it every transfer must catch it.
    while (q[pbp_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 200) begin
      ahb(1'b0, pbp_pkg::ADDR_STATUS, 32'h00000000, q);
      seen = seen | shifting;
      n++;
    end
    check(36'(n < 200), 36'h1, "step finished");
    check(seen, 1'b1, "shifting seen");
    steps = steps + 16'h0001;
    for (int i = 1; i < 12; i++)
      if ((sel == pbp_pkg::SEL_ALL_OUT && i > 1) || sel == 4'(i))
        exp_tap[i] = dir ? exp_tap[i] + 3'h1 : exp_tap[i] - 3'h1;
    check(phase_taps, packed_taps(), "phase taps");
    check(q[31:16], steps, "step count");
    check(q[pbp_pkg::STAT_DONE_BIT], 1'b1, "done back high");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; cnt_sel = 4'h0; cnt_wr = 1'b0; cnt_data = 18'h0;
    post_wr = 1'b0; post_data = 1'b0; steps = 16'h0; miscompares = 0; comparisons = 0;
    for (int i = 0; i < 12; i++) exp_tap[i] = pbp_pkg::TAP_RESET;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    check(div_factor, 36'h1, "reset factor");
    check(post_factor, 36'h1, "reset post factor");
    check(phase_taps, 36'h0, "reset taps");
    ahb(1'b0, pbp_pkg::ADDR_STATUS, 32'h0, rd);
    check(rd, 36'h2, "reset status");
    check(hresp, 1'b0, "okay response");
    $display("test reset done");
    for (int k = 0; k < 2; k++) begin
      cnt_write(k ? 4'h5 : 4'h1, {1'b1, 8'h03, 1'b1, 8'h05});
      check(div_factor, 36'h1, "bypassed factor");
      check(cnt_setting, {18'h0, 1'b1, 8'h03, 1'b1, 8'h05}, "setting");
      cnt_write(k ? 4'h5 : 4'h1, {1'b0, 8'h03, 1'b0, 8'h05});
      check(div_factor, 36'h8, "normal factor");
    end
    post_write(1'b0);
    check(post_factor, 36'h1, "post bypassed");
    post_write(1'b1);
    check(post_factor, {34'h0, pbp_pkg::POST_DIV_FACTOR}, "post active");
    $display("test bypass done");
    for (int c = 0; c < 12; c++) step(4'(c), 1'b1);
    repeat (3) step(4'h2, 1'b0);
    step(4'hc, 1'b1);
    step(4'hf, 1'b0);
    check(shifting, 1'b0, "idle after steps");
    $display("test steps done");
    ahb(1'b1, 8'h08, 32'hffffffff, rd);
    ahb(1'b0, 8'h08, 32'h0, rd);
    check(rd, 36'h0, "unmapped read");
    ahb(1'b0, pbp_pkg::ADDR_CTRL, 32'h0, rd);
    check(rd[8:0], 36'h00f, "control readback");
    $display("test registers done");
    summarize();
  end
endmodule
